// *** pkg/smcg_pkg.sv ***
// constants, types and register map of the sleep and clock gating block
// assumes a single 100 MHz master clock and a plain strobe register port
package smcg_pkg;
	localparam int CLK_MHZ = 100;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] MCU_PWR_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] DIV_CTRL_OFS = 4'h1;
	localparam logic [7:0] MCU_PWR_RST = 8'h00;
	localparam logic [7:0] MCU_PWR_WMASK = 8'h7b;
	localparam int PULLUP_OFF_BIT = 6;
	localparam int SLEEP_ALLOW_BIT = 5;
	localparam int KIND_HI = 4;
	localparam int KIND_LO = 3;
	localparam int SENSE_HI = 1;
	localparam int SENSE_LO = 0;
	localparam int UNLOCK_BIT = 7;
	localparam int DIV_HI = 3;
	localparam logic [3:0] DIV_RST = 4'h0;
	localparam logic [3:0] DIV_MAX_CODE = 4'h8;
	localparam logic [2:0] UNLOCK_CYC = 3'h4;
	localparam logic [2:0] STALL_CYC = 3'h4;
	localparam int STARTUP_CK = 6;
	localparam logic [1:0] SENSE_LEVEL = 2'h0;
	typedef enum logic [1:0] {
		SMCG_IDLE = 2'h0,
		SMCG_NOISE = 2'h1,
		SMCG_PDOWN = 2'h2,
		SMCG_RSVD = 2'h3
	} smcg_kind_t;
	typedef enum {S_RUN, S_SLEEP, S_START, S_STALL} smcg_state_t;
	typedef struct packed {
		logic ext_pin;
		logic pin_change;
		logic mem_ready;
		logic adc_done;
		logic other_io;
		logic wdt;
	} smcg_irq_t;
endpackage : smcg_pkg

// *** pkg/smcg_div_if.sv ***
// carrier between the control logic and the system clock prescaler
// assumes both ends sit on the undivided master clock
interface smcg_div_if;
	logic [3:0] code;
	logic load;
	logic tick;
	logic pending;
	modport ctrl (output code, output load, input tick, input pending);
	modport presc (input code, input load, output tick, output pending);
endinterface : smcg_div_if

// *** rtl/smcg_prescaler.sv ***
// system clock prescaler: a counter on the master clock giving tick enables
// assumes load is a one-cycle pulse carrying a legal division code
module smcg_prescaler (
	input wire logic sys_clk_i, // master clock
	input wire logic sys_rst_i, // synchronous reset, high
	smcg_div_if.presc div // division control
);
	import smcg_pkg::*;

	logic [7:0] cnt;
	logic [3:0] cur;
	logic [3:0] nxt;
	logic pend;
	logic tick_pre;

	function automatic logic [7:0] div_mask(input logic [3:0] c);
		div_mask = 8'((9'h001 << c) - 9'h001);
	endfunction : div_mask

	// counter is never read by software, so switch moment is not observable
	assign tick_pre = (cnt & div_mask(cur)) == div_mask(cur);

	// switch only at the end of an old period and restart the count, so the
	// transitional period is one whole old period then one whole new one
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cnt <= 8'h00;
			cur <= DIV_RST;
			nxt <= DIV_RST;
			pend <= 1'b0;
		end else begin
			if (div.load) begin
				nxt <= div.code;
			end
			if (tick_pre && pend) begin
				cur <= nxt;
				cnt <= 8'h00;
			end else begin
				cnt <= cnt + 8'h01;
			end
			pend <= div.load | (pend & ~tick_pre);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			div.tick <= 1'b0;
		end else begin
			div.tick <= tick_pre;
		end
	end

	assign div.pending = pend;

	// after a switch no tick may come sooner than one new period
	a_no_runt: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(tick_pre && pend && nxt != 4'h0) |=> !tick_pre)
		else $error("prescaler produced a runt period after switch");
endmodule : smcg_prescaler

// *** rtl/smcg_wake.sv ***
// wake source qualification per sleep kind
// assumes the interrupt inputs are already masked by their own enables
module smcg_wake (
	input wire smcg_pkg::smcg_kind_t kind_i, // sleep kind in force
	input wire smcg_pkg::smcg_irq_t irq_i, // pending enabled interrupts
	input wire logic [1:0] sense_i, // external pin sense setting
	output logic wake_o // wake request
);
	import smcg_pkg::*;

	logic level_pin;

	// deep modes have no clock to detect an edge, so only level sensing wakes
	assign level_pin = irq_i.ext_pin && sense_i == SENSE_LEVEL;

	always_comb begin
		case (kind_i)
			SMCG_IDLE: wake_o = |irq_i;
			SMCG_NOISE: wake_o = level_pin | irq_i.pin_change | irq_i.mem_ready
				| irq_i.adc_done | irq_i.wdt;
			SMCG_PDOWN: wake_o = level_pin | irq_i.pin_change | irq_i.wdt;
			default: wake_o = 1'b0;
		endcase
	end
endmodule : smcg_wake

// *** rtl/smcg_top.sv ***
// sleep mode controller, clock domain gating and prescaler control
// assumes the core pulses sleep_exec_i when it executes the sleep instruction
// and holds its own state while its clock enable is low
//
// Local design decisions: the address map and the address-and-strobe port.

// Operation
// - prescaler switches without glitches or runts
// - no transitional period shorter than both settings
// - divider counter on master clock, state hidden
// - new rate active within T1+T2 to T1+2*T2; here the switch waits at most T1 and the first new tick follows one T2 later
// - sleep only with sleep_allow set
// - kind field: idle, noise, power-down, reserved
// - wake stalls core four cycles after start-up
// - register file and RAM untouched by sleep
// - reset during sleep restarts at reset vector
// - idle gates only CPU and flash clocks
// - idle wakes on any interrupt source
// - enabled converter starts conversion on entry
// - noise mode halts I/O, CPU, flash clocks
// - noise mode wakes on listed sources only
// - power-down stops oscillator and all clocks
// - power-down wakes on listed sources only
// - deep modes wake on level pin only
// - reserved control bits read zero
// - division codes 0 to 8, rest reserved
// - divisor write only within unlock window
module smcg_top (
	input wire logic sys_clk_i, // master clock, 100 MHz
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic [smcg_pkg::ADDR_W-1:0] addr_i, // register address
	input wire logic [7:0] wr_data_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rd_data_o, // read data, cycle after rd_i
	input wire logic sleep_exec_i, // core executes sleep, pulse
	input wire smcg_pkg::smcg_irq_t irq_i, // pending enabled interrupts
	input wire logic rst_wake_i, // external, watchdog or brown-out reset
	input wire logic adc_enabled_i, // converter is enabled
	output logic cpu_clk_en_o, // CPU clock domain runs
	output logic flash_clk_en_o, // flash clock domain runs
	output logic io_clk_en_o, // I/O clock domain runs
	output logic adc_clk_en_o, // converter clock domain runs
	output logic osc_en_o, // main oscillator enabled
	output logic sys_tick_o, // prescaled system clock enable
	output logic adc_start_o, // start a conversion, pulse
	output logic wake_irq_o, // resume and service interrupt, pulse
	output logic reset_vector_o, // restart from reset vector, pulse
	output logic sleep_done_o, // sleep refused, continue, pulse
	output logic pullup_global_off_o, // global pull-up disable
	output logic [1:0] ext_irq_sense_o // external pin sense setting
);
	import smcg_pkg::*;

	localparam logic [7:0] STARTUP_LEN = 8'(STARTUP_CK);

	smcg_div_if div ();

	logic pullup_off;
	logic sleep_allow;
	smcg_kind_t kind;
	logic [1:0] sense;
	smcg_kind_t mode;
	smcg_state_t state;
	smcg_state_t next_state;
	logic [7:0] wait_cnt;
	logic [2:0] unlock_cnt;
	logic [3:0] div_sel;
	logic wake_req;
	logic enter;
	logic wr_mcu;
	logic wr_div;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = a == ofs;
	endfunction : hit

	assign wr_mcu = wr_i && hit(addr_i, MCU_PWR_OFS);
	assign wr_div = wr_i && hit(addr_i, DIV_CTRL_OFS);

	smcg_prescaler u_presc (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.div(div.presc)
	);

	smcg_wake u_wake (
		.kind_i(mode),
		.irq_i(irq_i),
		.sense_i(sense),
		.wake_o(wake_req)
	);

	// control register; reserved bits have no storage at all
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pullup_off <= MCU_PWR_RST[PULLUP_OFF_BIT];
			sleep_allow <= MCU_PWR_RST[SLEEP_ALLOW_BIT];
			kind <= smcg_kind_t'(MCU_PWR_RST[KIND_HI:KIND_LO]);
			sense <= MCU_PWR_RST[SENSE_HI:SENSE_LO];
		end else if (wr_mcu) begin
			pullup_off <= wr_data_i[PULLUP_OFF_BIT];
			sleep_allow <= wr_data_i[SLEEP_ALLOW_BIT];
			kind <= smcg_kind_t'(wr_data_i[KIND_HI:KIND_LO]);
			sense <= wr_data_i[SENSE_HI:SENSE_LO];
		end
	end

	// unlock window: opened only by the unlock bit alone, not extended by a
	// second unlock write, closed by timeout or by a divisor write
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			unlock_cnt <= 3'h0;
		end else if (wr_div && unlock_cnt != 3'h0 && !wr_data_i[UNLOCK_BIT]) begin
			unlock_cnt <= 3'h0;
		end else if (unlock_cnt != 3'h0) begin
			unlock_cnt <= unlock_cnt - 3'h1;
		end else if (wr_div && wr_data_i == (8'h01 << UNLOCK_BIT)) begin
			unlock_cnt <= UNLOCK_CYC;
		end
	end

	// reserved division codes are dropped, keeping the present rate
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			div_sel <= DIV_RST;
			div.load <= 1'b0;
		end else begin
			div.load <= 1'b0;
			if (wr_div && unlock_cnt != 3'h0 && !wr_data_i[UNLOCK_BIT]
				&& wr_data_i[DIV_HI:0] <= DIV_MAX_CODE) begin
				div_sel <= wr_data_i[DIV_HI:0];
				div.load <= 1'b1;
			end
		end
	end

	assign div.code = div_sel;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_i && hit(addr_i, MCU_PWR_OFS)) begin
			rd_data_o <= {1'b0, pullup_off, sleep_allow, kind, 1'b0, sense};
		end else if (rd_i && hit(addr_i, DIV_CTRL_OFS)) begin
			rd_data_o <= {unlock_cnt != 3'h0, 3'h0, div_sel};
		end else begin
			rd_data_o <= 8'h00;
		end
	end

	// sleep entry only when allowed and kind is not reserved
	assign enter = state == S_RUN && sleep_exec_i && sleep_allow && kind != SMCG_RSVD;

	always_comb begin
		next_state = state;
		case (state)
			S_RUN: begin
				if (enter) begin
					next_state = S_SLEEP;
				end
			end
			S_SLEEP: begin
				if (rst_wake_i) begin
					next_state = S_RUN;
				end else if (wake_req) begin
					next_state = S_START;
				end
			end
			S_START: begin
				if (rst_wake_i) begin
					next_state = S_RUN;
				end else if (wait_cnt == 8'h00) begin
					next_state = S_STALL;
				end
			end
			S_STALL: begin
				if (rst_wake_i || wait_cnt == 8'h00) begin
					next_state = S_RUN;
				end
			end
			default: next_state = S_RUN;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state <= S_RUN;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mode <= SMCG_IDLE;
		end else if (enter) begin
			mode <= kind;
		end
	end

	// only power-down needs the oscillator start-up before the stall
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wait_cnt <= 8'h00;
		end else if (state == S_SLEEP) begin
			wait_cnt <= mode == SMCG_PDOWN ? STARTUP_LEN - 8'h01 : 8'h00;
		end else if (state == S_START && wait_cnt == 8'h00) begin
			// loaded one below the count since the state leaves on zero
			wait_cnt <= 8'(STALL_CYC) - 8'h01;
		end else if (wait_cnt != 8'h00) begin
			wait_cnt <= wait_cnt - 8'h01;
		end
	end

	// enables follow next_state so they line up with state; the core and
	// memories are only frozen, never reset, while asleep
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cpu_clk_en_o <= 1'b1;
			flash_clk_en_o <= 1'b1;
		end else begin
			cpu_clk_en_o <= next_state == S_RUN;
			flash_clk_en_o <= next_state == S_RUN;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			io_clk_en_o <= 1'b1;
			adc_clk_en_o <= 1'b1;
			osc_en_o <= 1'b1;
		end else begin
			io_clk_en_o <= next_state == S_RUN || next_state == S_STALL
				|| (next_state != S_RUN && next_mode() == SMCG_IDLE);
			adc_clk_en_o <= next_state == S_RUN || next_state == S_STALL
				|| next_mode() != SMCG_PDOWN;
			osc_en_o <= !(next_state == S_SLEEP && next_mode() == SMCG_PDOWN);
		end
	end

	function automatic smcg_kind_t next_mode();
		next_mode = enter ? kind : mode;
	endfunction : next_mode

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			adc_start_o <= 1'b0;
			wake_irq_o <= 1'b0;
			reset_vector_o <= 1'b0;
			sleep_done_o <= 1'b0;
		end else begin
			adc_start_o <= enter && adc_enabled_i && kind != SMCG_PDOWN;
			wake_irq_o <= state == S_STALL && next_state == S_RUN && !rst_wake_i;
			reset_vector_o <= state != S_RUN && rst_wake_i;
			sleep_done_o <= state == S_RUN && sleep_exec_i && !enter;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sys_tick_o <= 1'b0;
			pullup_global_off_o <= 1'b0;
			ext_irq_sense_o <= 2'h0;
		end else begin
			sys_tick_o <= div.tick;
			pullup_global_off_o <= pullup_off;
			ext_irq_sense_o <= sense;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_sleep_refused: assert property (sleep_exec_i && state == S_RUN && !sleep_allow
		|=> state == S_RUN ##0 sleep_done_o)
		else $error("sleep entered without sleep_allow");
	a_idle_clocks: assert property (state == S_SLEEP && mode == SMCG_IDLE
		|-> !cpu_clk_en_o && !flash_clk_en_o && io_clk_en_o && adc_clk_en_o && osc_en_o)
		else $error("idle clock gating wrong");
	a_noise_clocks: assert property (state == S_SLEEP && mode == SMCG_NOISE
		|-> !cpu_clk_en_o && !io_clk_en_o && adc_clk_en_o && osc_en_o)
		else $error("noise reduction clock gating wrong");
	a_pdown_clocks: assert property (state == S_SLEEP && mode == SMCG_PDOWN
		|-> !cpu_clk_en_o && !io_clk_en_o && !adc_clk_en_o && !osc_en_o)
		else $error("power-down clock gating wrong");
	a_stall_four: assert property ($rose(state == S_STALL)
		|-> (state == S_STALL && !cpu_clk_en_o)[*4] ##1 cpu_clk_en_o ##0 wake_irq_o)
		else $error("wake stall not four cycles");
	a_reset_wake: assert property (state == S_SLEEP && rst_wake_i
		|=> reset_vector_o && !wake_irq_o && cpu_clk_en_o)
		else $error("reset during sleep not taken");
	a_adc_autostart: assert property (enter && adc_enabled_i && kind == SMCG_NOISE
		|=> adc_start_o ##0 state == S_SLEEP)
		else $error("conversion not started on sleep entry");
	a_pdown_sources: assert property (state == S_SLEEP && mode == SMCG_PDOWN && !rst_wake_i
		&& !irq_i.pin_change && !irq_i.wdt && !(irq_i.ext_pin && sense == SENSE_LEVEL)
		|=> state == S_SLEEP)
		else $error("power-down woke on a barred source");
	a_reserved_zero: assert property (rd_i && hit(addr_i, MCU_PWR_OFS)
		|=> rd_data_o[7] == 1'b0 && rd_data_o[2] == 1'b0 && rd_data_o[5] == $past(sleep_allow))
		else $error("reserved control bits not zero");
	a_unlock_window: assert property (unlock_cnt == 3'h0 && wr_div && !wr_data_i[UNLOCK_BIT]
		|=> $stable(div_sel) && !div.load)
		else $error("divisor changed outside unlock window");
	// the switch waits at most one old period, and the longest is 256 cycles
	a_switch_bound: assert property (div.load && !div.pending
		|=> div.pending ##[1:256] !div.pending)
		else $error("prescaler switch not taken within one old period");
endmodule : smcg_top

// *** bench/smcg_core_model.sv ***
// stand-in for the processor core and its wake sources
// assumes the bench drives the request inputs at the rising clock edge
module smcg_core_model (
	input wire logic sys_clk_i, // master clock
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic sleep_req_i, // bench asks for a sleep instruction
	input wire smcg_pkg::smcg_irq_t irq_req_i, // bench raises sources
	input wire logic rst_req_i, // bench asks for a reset
	input wire logic cpu_clk_en_i, // core clock runs
	input wire logic wake_irq_i, // interrupt serviced
	input wire logic reset_vector_i, // core restarted
	output logic sleep_exec_o, // sleep instruction executes
	output smcg_pkg::smcg_irq_t irq_o, // pending sources
	output logic rst_wake_o // reset request
);
	timeunit 1ns;
	timeprecision 1ps;
	import smcg_pkg::*;
	// a halted core executes nothing
	always_ff @(posedge sys_clk_i) begin
		sleep_exec_o <= !sys_rst_i && sleep_req_i && cpu_clk_en_i;
	end
	// flags stay raised until serviced, so a level wake is held long enough
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || wake_irq_i || reset_vector_i) begin
			irq_o <= irq_req_i;
		end else begin
			irq_o <= irq_o | irq_req_i;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		rst_wake_o <= !sys_rst_i && rst_req_i;
	end
endmodule : smcg_core_model

// *** bench/smcg_top_tb.sv ***
// self-checking bench for the sleep and clock gating block
// assumes the core model file and the design files are compiled first
module smcg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import smcg_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [7:0] wr_data = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rd_data;
	logic sleep_exec, rst_wake, sleep_req = 1'b0, rst_req = 1'b0, adc_en = 1'b1;
	smcg_irq_t irq, irq_req = '0;
	logic cpu, flash, io, adc, osc, tick, adc_start, wake_irq, rvec, done, pull;
	logic [1:0] sense;
	logic [7:0] en_v;
	int miscompares = 0;
	int compares = 0;
	assign en_v = {3'h0, cpu, flash, io, adc, osc};
	always #5 sys_clk_i = ~sys_clk_i;
	smcg_top DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
		.wr_data_i(wr_data), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data),
		.sleep_exec_i(sleep_exec), .irq_i(irq), .rst_wake_i(rst_wake),
		.adc_enabled_i(adc_en), .cpu_clk_en_o(cpu), .flash_clk_en_o(flash),
		.io_clk_en_o(io), .adc_clk_en_o(adc), .osc_en_o(osc), .sys_tick_o(tick),
		.adc_start_o(adc_start), .wake_irq_o(wake_irq), .reset_vector_o(rvec),
		.sleep_done_o(done), .pullup_global_off_o(pull), .ext_irq_sense_o(sense));
	smcg_core_model core (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.sleep_req_i(sleep_req), .irq_req_i(irq_req), .rst_req_i(rst_req),
		.cpu_clk_en_i(cpu), .wake_irq_i(wake_irq), .reset_vector_i(rvec),
		.sleep_exec_o(sleep_exec), .irq_o(irq), .rst_wake_o(rst_wake));
	task automatic summarize;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge sys_clk_i) addr <= a;
		wr_data <= d;
		wr <= 1'b1;
		@(posedge sys_clk_i) wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge sys_clk_i) addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk_i) rd <= 1'b0;
		#1 v = rd_data;
	endtask : rd_reg
	function automatic logic [7:0] en_exp(input logic [1:0] k);
		case (k)
			SMCG_IDLE: return 8'h07;
			SMCG_NOISE: return 8'h03;
			SMCG_PDOWN: return 8'h00;
			default: return 8'h1f;
		endcase
	endfunction : en_exp
	// the core model adds one cycle between the request and the instruction
	task automatic sleep_in(input logic [1:0] k, input logic allow, input logic [1:0] s);
		logic refused;
		refused = !allow || k == 2'h3;
		wr_reg(MCU_PWR_OFS, {2'h0, allow, k, 1'b0, s});
		@(posedge sys_clk_i) sleep_req <= 1'b1;
		@(posedge sys_clk_i) sleep_req <= 1'b0;
		@(posedge sys_clk_i) #1;
		chk("sleep_done", {7'h0, refused}, {7'h0, done});
		chk("clk_en", refused ? 8'h1f : en_exp(k), en_v);
		chk("adc_start", {7'h0, !refused && adc_en && k < 2'h2}, {7'h0, adc_start});
	endtask : sleep_in
	// exp_n of 15 means the source must not wake the block at all
	task automatic wake(input smcg_irq_t v, input logic r, input int exp_n);
		int n;
		n = 0;
		@(posedge sys_clk_i) irq_req <= v;
		rst_req <= r;
		@(posedge sys_clk_i) irq_req <= '0;
		rst_req <= 1'b0;
		do begin
			@(posedge sys_clk_i) #1;
			n++;
		end while (!(r ? rvec : wake_irq) && n < 15);
		chk("wake_cycles", exp_n[7:0], n[7:0]);
	endtask : wake
	task automatic tick_gaps(input int n, output int last, output int mn);
		int t;
		t = 0;
		mn = 1000;
		last = 0;
		while (n > 0) begin
			@(posedge sys_clk_i) #1;
			t++;
			if (tick === 1'b1) begin
				last = t;
				mn = t < mn ? t : mn;
				t = 0;
				n--;
			end
		end
	endtask : tick_gaps
	task automatic div_test(input logic [3:0] c, input logic [3:0] eff, input logic [3:0] old);
		int last, mn;
		logic [7:0] v;
		do @(posedge sys_clk_i) #1; while (tick !== 1'b1);
		fork
			begin
				wr_reg(DIV_CTRL_OFS, 8'h80);
				wr_reg(DIV_CTRL_OFS, {4'h0, c});
			end
			// at divide 1 about seven old ticks pass before the switch shows
			tick_gaps(12, last, mn);
		join
		chk("tick_period", 8'((1 << eff) - 1), 8'(last - 1));
		chk("tick_min_ok", 8'h1, 8'(mn >= (1 << (eff < old ? eff : old))));
		rd_reg(DIV_CTRL_OFS, v);
		chk("div_ctrl", {4'h0, eff}, v);
	endtask : div_test
	initial begin
		#500000;
		miscompares++;
		summarize();
	end
	initial begin
		logic [7:0] v, d;
		logic [3:0] cur, c;
		void'($urandom(32'h3ff1));
		repeat (6) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		rd_reg(MCU_PWR_OFS, v);
		chk("pwr_reset", MCU_PWR_RST, v);
		rd_reg(DIV_CTRL_OFS, v);
		chk("div_reset", {4'h0, DIV_RST}, v);
		chk("clk_en", 8'h1f, en_v);
		for (int i = 0; i < 8; i++) begin
			d = i == 0 ? 8'hff : 8'($urandom);
			wr_reg(MCU_PWR_OFS, d);
			rd_reg(MCU_PWR_OFS, v);
			chk("pwr_ctrl", d & MCU_PWR_WMASK, v);
			chk("pins", {5'h0, d[6], d[1:0]}, {5'h0, pull, sense});
		end
		wr_reg(4'h7, 8'hff);
		rd_reg(4'h7, v);
		chk("unmapped", 8'h00, v);
		cur = DIV_RST;
		for (int i = 0; i < 7; i++) begin
			c = i == 0 ? DIV_MAX_CODE : i == 1 ? 4'h9 : 4'($urandom_range(15));
			div_test(c, c > DIV_MAX_CODE ? cur : c, cur);
			cur = c > DIV_MAX_CODE ? cur : c;
		end
		wr_reg(DIV_CTRL_OFS, 8'h80);
		rd_reg(DIV_CTRL_OFS, v);
		chk("div_window", {4'h8, cur}, v);
		repeat (4) @(posedge sys_clk_i);
		wr_reg(DIV_CTRL_OFS, 8'h01);
		rd_reg(DIV_CTRL_OFS, v);
		chk("div_late", {4'h0, cur}, v);
		sleep_in(SMCG_RSVD, 1'b1, 2'h0);
		sleep_in(SMCG_IDLE, 1'b0, 2'h0);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk_i) adc_en <= i == 0 ? 1'b0 : 1'($urandom);
			sleep_in(SMCG_IDLE, 1'b1, 2'h0);
			wake(smcg_irq_t'(6'h1 << i), 1'b0, 2 + STALL_CYC);
			chk("clk_en", 8'h1f, en_v);
			rd_reg(MCU_PWR_OFS, v);
			chk("pwr_kept", 8'h20, v);
		end
		@(posedge sys_clk_i) adc_en <= 1'b1;
		sleep_in(SMCG_NOISE, 1'b1, 2'h0);
		wake(smcg_irq_t'(6'h02), 1'b0, 15);
		chk("clk_en", 8'h03, en_v);
		wake(smcg_irq_t'(6'h04), 1'b0, 2 + STALL_CYC);
		sleep_in(SMCG_PDOWN, 1'b1, 2'($urandom_range(3, 1)));
		wake(smcg_irq_t'(6'h2e), 1'b0, 15);
		chk("clk_en", 8'h00, en_v);
		wake(smcg_irq_t'(6'h01), 1'b0, 1 + STARTUP_CK + STALL_CYC);
		sleep_in(SMCG_PDOWN, 1'b1, SENSE_LEVEL);
		wake(smcg_irq_t'(6'h20), 1'b0, 1 + STARTUP_CK + STALL_CYC);
		sleep_in(SMCG_PDOWN, 1'b1, 2'h0);
		wake('0, 1'b1, 1);
		chk("clk_en", 8'h1f, en_v);
		summarize();
	end
endmodule : smcg_top_tb
